// ### design/tcc_capture_compare.sv
// Two capture/compare channels of a 16-bit timer behind an Avalon-MM slave.
// Assumes the shared counter, prescaler and modulo logic sit outside and
// drive counterIn synchronously; pins are synchronous to clock.
`timescale 1ns/10ps
`include "tcc_defs.svh"

module tcc_capture_compare
  import tcc_pkg::*;
#(
  parameter int ADDR_W  = 9,   // Byte address width
  parameter int VALUE_W = 16   // Counter and value width
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire tcc_cnt_s          counterIn,
  input  wire logic [1:0]        channelPinIn,
  output logic      [1:0]        channelPinOut,
  output logic      [1:0]        channelPinOe_n,
  output logic      [1:0]        timerOwnsPin,
  output logic      [1:0]        channelIrq
);

  // Refuse shapes the decode and struct cannot serve
  if (VALUE_W != 16 || ADDR_W < 9 || ADDR_W > 10) begin : g_bad
    $error("tcc_capture_compare: unsupported ADDR_W or VALUE_W");
  end

  // One-hot register select from a word index
  function automatic logic [5:0] regSel(input logic [7:0] idx);
    regSel    = 6'h00;
    regSel[0] = (idx == `TCC_IDX_C0_CTRL);
    regSel[1] = (idx == `TCC_IDX_C0_HIGH);
    regSel[2] = (idx == `TCC_IDX_C0_LOW);
    regSel[3] = (idx == `TCC_IDX_C1_CTRL);
    regSel[4] = (idx == `TCC_IDX_C1_HIGH);
    regSel[5] = (idx == `TCC_IDX_C1_LOW);
  endfunction

  // Mode from the control byte; channel 1 never holds bufMode
  function automatic tcc_mode_e chanMode(input tcc_ctrl_s c);
    if (!c.elsHi && !c.elsLo)
      chanMode = MODE_PRESET;
    else if (c.bufMode)
      chanMode = MODE_BUFFERED;
    else if (c.unbufMode)
      chanMode = MODE_COMPARE;
    else
      chanMode = MODE_CAPTURE;
  endfunction

  // Output level after a compare for the edge/level bits
  function automatic logic cmpAction(input logic [1:0] els, input logic cur);
    if (els == 2'b01)
      cmpAction = ~cur;
    else
      cmpAction = els[0];
  endfunction

  // Bus side state
  logic              ack_r;       // Second cycle of a request
  logic [31:0]       rdata_r;     // Registered read data
  logic [7:0]        wordIdx;     // Word index of the access
  logic [5:0]        sel;         // Decoded register
  logic              reqPend;     // Request seen, not yet taken
  logic              rdAcc;       // Read taken this edge
  logic              wrAcc;       // Write taken this edge
  logic [7:0]        rdByte;      // Read mux

  // Channel state
  tcc_ctrl_s         ctrl_r [2];  // Control/status bytes
  logic [15:0]       value_r [2]; // Value pairs, not reset
  logic [15:0]       activeCmp_r; // Buffered compare in use
  logic              lastWr_r;    // Buffer last completed by software
  logic [1:0]        armed_r;     // Flag read while set
  logic [1:0]        capLock_r;   // Capture blocked by high read
  logic [1:0]        cmpLock_r;   // Compare blocked by high write
  logic [1:0]        pinPrev_r;   // Previous pin sample
  logic [1:0]        maxEff_r;    // Max duty in this period
  logic [1:0]        outLevel_r;  // Internal channel output

  // Channel decode
  tcc_mode_e         mode [2];    // Mode per channel
  logic [1:0]        active;      // Channel register enabled
  logic [1:0]        isOut;       // Compare or PWM mode
  logic [1:0]        ocBits;      // Mode bits not 0:0
  logic [1:0]        capture;     // Capture event
  logic [1:0]        compare;     // Compare event
  logic [1:0]        evt;         // Any flag-setting event
  logic [1:0]        ctrlWr;      // Control byte written
  logic [1:0]        clearReq;    // Valid flag clear
  logic [15:0]       cntNow;      // Counter as the channels see it

  // Bus handshake: every access waits exactly one cycle
  assign wordIdx     = 8'(address[ADDR_W-1:2]);
  assign sel         = regSel(wordIdx);
  assign reqPend     = (read | write) & ~ack_r;
  assign waitrequest = reqPend;
  assign rdAcc       = read & ack_r;
  assign wrAcc       = write & ack_r & byteenable[0];
  assign readdata    = rdata_r;

  // Acknowledge flop
  always_ff @(posedge clock) begin
    if (!resetn)
      ack_r <= 1'b0;
    else
      ack_r <= reqPend;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdByte = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (sel[3*i])
        rdByte = ctrl_r[i];
      if (sel[3*i+1])
        rdByte = value_r[i][15:8];
      if (sel[3*i+2])
        rdByte = value_r[i][7:0];
    end
  end

  // Read data captured while waitrequest is high
  always_ff @(posedge clock) begin
    if (!resetn)
      rdata_r <= 32'h00000000;
    else if (reqPend)
      rdata_r <= {`TCC_READ_ZERO, rdByte};
  end

  // A counter reset is seen as a cleared count, nothing else changes
  assign cntNow = counterIn.reset ? 16'h0000 : counterIn.value;

  // Per-channel event decode
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode[i]   = chanMode(ctrl_r[i]);
      // Buffered channel 0 takes over channel 1
      active[i] = (i == 0) ? 1'b1 : ~ctrl_r[0].bufMode;
      isOut[i]  = (mode[i] == MODE_COMPARE) || (mode[i] == MODE_BUFFERED);
      ocBits[i] = ctrl_r[i].unbufMode | ctrl_r[0].bufMode;
      // Edge selection, stop inhibit and byte lock
      capture[i] = active[i] && (mode[i] == MODE_CAPTURE)
                 && ((ctrl_r[i].elsLo && channelPinIn[i] && !pinPrev_r[i])
                  || (ctrl_r[i].elsHi && !channelPinIn[i] && pinPrev_r[i]))
                 && !counterIn.stop && !capLock_r[i];
      // Buffered channel compares against the loaded buffer
      compare[i] = active[i] && isOut[i] && !cmpLock_r[i]
                 && (cntNow == ((mode[i] == MODE_BUFFERED) ? activeCmp_r
                                                            : value_r[i]));
      evt[i]      = capture[i] | compare[i];
      ctrlWr[i]   = wrAcc && sel[3*i] && active[i];
      clearReq[i] = ctrlWr[i] && !writedata[`TCC_BIT_FLAG] && armed_r[i];
    end
  end

  // Control bytes and event flags
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_r[0] <= `TCC_CTRL_RESET;
      ctrl_r[1] <= `TCC_CTRL_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctrlWr[i])
          ctrl_r[i] <= {ctrl_r[i].flag, writedata[6:0]};
        // Set beats clear; writing one never sets
        if (evt[i])
          ctrl_r[i].flag <= 1'b1;
        else if (clearReq[i])
          ctrl_r[i].flag <= 1'b0;
        else
          ctrl_r[i].flag <= ctrl_r[i].flag;
      end
      // Buffered bit exists in channel 0 only
      ctrl_r[1].bufMode <= 1'b0;
    end
  end

  // Clear arming: read with flag set, spent by a write or an event
  always_ff @(posedge clock) begin
    if (!resetn)
      armed_r <= 2'b00;
    else begin
      for (int i = 0; i < 2; i++) begin
        if (evt[i])
          armed_r[i] <= 1'b0;
        else if (rdAcc && sel[3*i] && ctrl_r[i].flag)
          armed_r[i] <= 1'b1;
        else if (ctrlWr[i])
          armed_r[i] <= 1'b0;
      end
    end
  end

  // Value pairs; left unreset on purpose, software must load them
  always_ff @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (capture[i])
        value_r[i] <= cntNow;
      else if (wrAcc && sel[3*i+1])
        value_r[i][15:8] <= writedata[7:0];
      else if (wrAcc && sel[3*i+2])
        value_r[i][7:0] <= writedata[7:0];
    end
  end

  // Byte coherence locks
  always_ff @(posedge clock) begin
    if (!resetn) begin
      capLock_r <= 2'b00;
      cmpLock_r <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rdAcc && sel[3*i+1] && !ocBits[i])
          capLock_r[i] <= 1'b1;
        else if (rdAcc && sel[3*i+2])
          capLock_r[i] <= 1'b0;
        if (wrAcc && sel[3*i+1] && ocBits[i])
          cmpLock_r[i] <= 1'b1;
        else if (wrAcc && sel[3*i+2])
          cmpLock_r[i] <= 1'b0;
      end
    end
  end

  // Double buffer; loading only at overflow avoids a mid-period glitch
  always_ff @(posedge clock) begin
    if (!resetn)
      lastWr_r <= 1'b0;
    else if (wrAcc && sel[5])
      lastWr_r <= 1'b1;
    else if (wrAcc && sel[2])
      lastWr_r <= 1'b0;
  end

  // Compare value in use by buffered channel 0
  always_ff @(posedge clock) begin
    if (mode[0] != MODE_BUFFERED)
      activeCmp_r <= value_r[0];
    else if (counterIn.overflow && !cmpLock_r[lastWr_r])
      activeCmp_r <= value_r[lastWr_r];
  end

  // Pin history for edge detection
  always_ff @(posedge clock) begin
    if (!resetn)
      pinPrev_r <= 2'b00;
    else
      pinPrev_r <= channelPinIn;
  end

  // Max duty is sampled at period start only
  always_ff @(posedge clock) begin
    if (!resetn)
      maxEff_r <= 2'b00;
    else begin
      for (int i = 0; i < 2; i++) begin
        if (counterIn.overflow)
          maxEff_r[i] <= ctrl_r[i].maxDuty;
      end
    end
  end

  // Channel output level
  always_ff @(posedge clock) begin
    if (!resetn)
      outLevel_r <= `TCC_OUT_RESET;
    else begin
      for (int i = 0; i < 2; i++) begin
        if (active[i]) begin
          unique case (mode[i])
            // Level waits behind the port for a mode
            MODE_PRESET:
              outLevel_r[i] <= ~ctrl_r[i].unbufMode;
            // Capture never moves the output; toggle bit ignored
            MODE_CAPTURE:
              outLevel_r[i] <= outLevel_r[i];
            MODE_COMPARE, MODE_BUFFERED: begin
              if (counterIn.overflow && ctrl_r[i].tov)
                outLevel_r[i] <= ~outLevel_r[i];
              else if (counterIn.overflow && ctrl_r[i].maxDuty
                       && ctrl_r[i].elsHi != ctrl_r[i].elsLo)
                outLevel_r[i] <= ~ctrl_r[i].elsLo;
              else if (compare[i] && !(maxEff_r[i] && !ctrl_r[i].tov))
                outLevel_r[i] <= cmpAction({ctrl_r[i].elsHi, ctrl_r[i].elsLo},
                                           outLevel_r[i]);
            end
          endcase
        end
      end
    end
  end

  // Pin ownership and interrupt requests
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      timerOwnsPin[i]   = active[i] && (mode[i] != MODE_PRESET);
      // Capture senses, compare drives
      channelPinOe_n[i] = !(active[i] && isOut[i]);
      channelIrq[i]     = active[i] && ctrl_r[i].flag && ctrl_r[i].irqEn;
    end
  end
  assign channelPinOut = outLevel_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_capFlag;
    capture[0] |=> ctrl_r[0].flag;
  endproperty
  a_capFlag: assert property (p_capFlag)
    else $error("capture did not set flag");

  property p_cmpFlag;
    compare[0] |=> ctrl_r[0].flag && (value_r[0] == $past(value_r[0]));
  endproperty
  a_cmpFlag: assert property (p_cmpFlag)
    else $error("compare did not set flag");

  property p_clearLoses;
    evt[0] && ctrlWr[0] && !writedata[7] |=> ctrl_r[0].flag;
  endproperty
  a_clearLoses: assert property (p_clearLoses)
    else $error("flag cleared despite new event");

  property p_clearNeedsRead;
    !armed_r[0] && ctrl_r[0].flag |=> ctrl_r[0].flag;
  endproperty
  a_clearNeedsRead: assert property (p_clearNeedsRead)
    else $error("flag cleared without prior read");

  property p_writeOne;
    !ctrl_r[1].flag && !evt[1] |=> !ctrl_r[1].flag;
  endproperty
  a_writeOne: assert property (p_writeOne)
    else $error("flag set without event");

  property p_irq;
    $rose(ctrl_r[0].flag) && ctrl_r[0].irqEn |-> channelIrq[0];
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing");

  property p_ch1Off;
    ctrl_r[0].bufMode |-> channelPinOe_n[1] && !timerOwnsPin[1] && !channelIrq[1];
  endproperty
  a_ch1Off: assert property (p_ch1Off)
    else $error("channel 1 active in buffered mode");

  property p_preset;
    mode[0] == MODE_PRESET ##1 mode[0] == MODE_PRESET
      |-> channelPinOut[0] == ~$past(ctrl_r[0].unbufMode);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset level wrong");

  property p_ovfWins;
    counterIn.overflow && ctrl_r[0].tov && isOut[0] && compare[0]
      |=> channelPinOut[0] == ~$past(channelPinOut[0]);
  endproperty
  a_ovfWins: assert property (p_ovfWins)
    else $error("overflow did not take precedence");

  property p_stopInhibit;
    counterIn.stop |-> !capture[0] && !capture[1];
  endproperty
  a_stopInhibit: assert property (p_stopInhibit)
    else $error("capture while counter stopped");

  property p_capLock;
    capLock_r[0] |-> ##1 (value_r[0] == $past(value_r[0])) || $past(wrAcc);
  endproperty
  a_capLock: assert property (p_capLock)
    else $error("capture through high-byte lock");

  property p_cmpLock;
    cmpLock_r[0] |-> !compare[0];
  endproperty
  a_cmpLock: assert property (p_cmpLock)
    else $error("compare through high-byte lock");

endmodule

// ### design/tcc_defs.svh
// Constants of the two-channel capture/compare block: register indices,
// control bit positions, reset values and read-data padding.
// Assumes inclusion by bare name from the block.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// Register indices; byte address is four times the index
`define TCC_IDX_C0_CTRL  8'h56
`define TCC_IDX_C0_HIGH  8'h57
`define TCC_IDX_C0_LOW   8'h58
`define TCC_IDX_C1_CTRL  8'h59
`define TCC_IDX_C1_HIGH  8'h5A
`define TCC_IDX_C1_LOW   8'h5B
// Control field positions
`define TCC_BIT_FLAG     7
`define TCC_BIT_IRQEN    6
`define TCC_BIT_BUFMODE  5
`define TCC_BIT_UNBUF    4
`define TCC_BIT_ELSHI    3
`define TCC_BIT_ELSLO    2
`define TCC_BIT_TOV      1
`define TCC_BIT_MAXDUTY  0
// Reset values and read-data padding
`define TCC_CTRL_RESET   8'h00
`define TCC_OUT_RESET    2'h3
`define TCC_READ_ZERO    24'h000000
`endif

// ### design/tcc_pkg.sv
// Types shared by the capture/compare block and its bench.
// Assumes tcc_defs.svh holds all numeric constants except the mode codes below.
package tcc_pkg;
  // Channel control/status byte, bit 7 down to bit 0
  typedef struct packed {
    logic flag;        // channel_event_flag
    logic irqEn;       // channel_irq_enable
    logic bufMode;     // buffered_mode_select, channel 0 only
    logic unbufMode;   // unbuffered_mode_select
    logic elsHi;       // edge_level_select_hi
    logic elsLo;       // edge_level_select_lo
    logic tov;         // toggle_on_overflow
    logic maxDuty;     // max_duty_force
  } tcc_ctrl_s;

  // Shared counter seen from the channels
  typedef struct packed {
    logic [15:0] value;     // Counter value
    logic        overflow;  // One-cycle overflow event
    logic        stop;      // counter_stop level
    logic        reset;     // Counter reset pulse
  } tcc_cnt_s;

  // Channel operating mode, Gray coded
  typedef enum logic [1:0] {
    MODE_PRESET   = 2'b00,
    MODE_CAPTURE  = 2'b01,
    MODE_COMPARE  = 2'b11,
    MODE_BUFFERED = 2'b10
  } tcc_mode_e;
endpackage

// ### tb/tcc_pin_model.sv
// Pin model for the far side: the external source and the channel pads.
// Assumes active-low drive enables from the block and a single clock.
`timescale 1ns/10ps
module tcc_pin_model (
  input  wire logic [1:0] srcLevel,  // Level the external source drives
  input  wire logic [1:0] pinOut,    // Block output level
  input  wire logic [1:0] pinOe_n,   // Block drive enable, active low
  output logic      [1:0] pinIn      // Resolved pad level
);
  // Pad follows the block while it drives, else the source owns it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pinIn[i] = pinOe_n[i] ? srcLevel[i] : pinOut[i];
    end
  end
endmodule

// ### tb/timer_capture_compare_channels_tb.sv
// Self-checking bench of the two-channel capture/compare block.
// Assumes the pin model beside the block; counter driven by the bench.
`timescale 1ns/10ps
module timer_capture_compare_channels_tb;
  import tcc_pkg::*;
  logic        clock;        // 10 MHz bus clock
  logic        resetn;       // Synchronous reset, active low
  logic [8:0]  address;      // Byte address
  logic        read;         // Read strobe
  logic        write;        // Write strobe
  logic [31:0] writedata;    // Write data, low byte used
  logic [3:0]  byteenable;   // Byte lanes
  logic [31:0] readdata;     // Read data
  logic        waitrequest;  // Slave stall
  tcc_cnt_s    cnt;          // Stand-in for the shared counter
  logic [1:0]  pinDrv;       // External source levels
  logic [1:0]  pinIn;        // Resolved pad levels
  logic [1:0]  pinOut;       // Channel output levels
  logic [1:0]  pinOe_n;      // Drive enables
  logic [1:0]  owns;         // Pin connected to channel
  logic [1:0]  irq;          // Channel interrupt requests
  int          miscompares;  // Mismatch count
  int          compares;     // Comparison count
  logic [31:0] lfsrR;        // Random state
  logic [7:0]  rd;           // Last read byte
  logic [7:0]  hi;           // Saved high byte
  logic [15:0] v;            // Compare value
  logic [15:0] w;            // Second compare value
  int          exO;          // Model of channel 0 output level
  int          ex;           // Model of expected flag

  tcc_capture_compare tcc_capture_compare_inst (
    .clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .counterIn(cnt),
    .channelPinIn(pinIn), .channelPinOut(pinOut), .channelPinOe_n(pinOe_n),
    .timerOwnsPin(owns), .channelIrq(irq)
  );
  tcc_pin_model tcc_pin_model_inst (
    .srcLevel(pinDrv), .pinOut(pinOut), .pinOe_n(pinOe_n), .pinIn(pinIn)
  );

  // Free-running clock, 100 ns period
  always #50 clock = ~clock;

  // Galois-free shift register, fixed seed keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One comparison; case inequality so unknowns never match
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Avalon access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input bit wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    address   <= {idx[6:0], 2'b00};
    read      <= !wr;
    write     <= wr;
    writedata <= {24'h000000, wd};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) miscompares++;
    // Data taken at the accepting edge, request dropped right after it
    rd = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    // Two edges so follow-on register effects have settled
    repeat (2) @(posedge clock);
  endtask

  // Counter shows cv (and overflow) for one cycle, then an idle value
  task automatic tick(input logic [15:0] cv, input logic ov);
    @(posedge clock);
    cnt.value    <= cv;
    cnt.overflow <= ov;
    @(posedge clock);
    cnt.value    <= cv ^ 16'h8000;
    cnt.overflow <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // Source moves a pin and holds it stable for several clocks
  task automatic pin(input int ch, input logic lv);
    @(posedge clock);
    pinDrv[ch] <= lv;
    repeat (3) @(posedge clock);
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    miscompares++;
    end_of_test;
  end

  // Main sequence
  initial begin
    clock = 1'b0; resetn = 1'b0; address = '0; read = 1'b0; write = 1'b0;
    writedata = '0; byteenable = 4'hF; cnt = '0; pinDrv = 2'b00;
    miscompares = 0; compares = 0; lfsrR = 32'h12948808;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    // Reset state and an unmapped place
    bus(0, 8'h56, 8'h00); chk("ctrl0", rd, 16'h0000);
    bus(0, 8'h59, 8'h00); chk("ctrl1", rd, 16'h0000);
    chk("pinOut", pinOut, 16'h0003);
    chk("irq", irq, 16'h0000);
    bus(0, 8'h50, 8'h00); chk("unmapped", rd, 16'h0000);
    // Capture on each edge choice, both directions
    for (int e = 1; e < 4; e++) begin
      // Counter stopped and held cleared around the mode change
      cnt.stop  <= 1'b1;
      cnt.reset <= 1'b1;
      bus(1, 8'h56, 8'(8'h40 | (e << 2)));
      cnt.stop  <= 1'b0;
      cnt.reset <= 1'b0;
      for (int d = 0; d < 2; d++) begin
        lfsrR = lfsr(lfsrR);
        cnt.value <= lfsrR[15:0];
        pin(0, d == 0);
        ex = (d == 0) ? e & 1 : e >> 1;
        bus(0, 8'h56, 8'h00); chk("flag", rd[7], ex);
        chk("irq0", irq[0], ex);
        if (ex == 1) begin
          bus(0, 8'h57, 8'h00); hi = rd;
          bus(0, 8'h58, 8'h00); chk("capture", {hi, rd}, lfsrR[15:0]);
          bus(1, 8'h56, 8'(8'hC0 | (e << 2)));
          bus(0, 8'h56, 8'h00); chk("flagKeep", rd[7], 1);
          bus(1, 8'h56, 8'(8'h40 | (e << 2)));
          bus(0, 8'h56, 8'h00); chk("flagClr", rd[7], 0);
        end
      end
    end
    // Stop inhibits captures; high read locks until low read
    cnt.stop <= 1'b1;
    pin(0, 1'b1);
    bus(0, 8'h56, 8'h00); chk("stopped", rd[7], 0);
    cnt.stop <= 1'b0;
    bus(0, 8'h57, 8'h00);
    pin(0, 1'b0);
    bus(0, 8'h56, 8'h00); chk("locked", rd[7], 0);
    bus(0, 8'h58, 8'h00);
    pin(0, 1'b1);
    bus(0, 8'h56, 8'h00); chk("unlocked", rd[7], 1);
    // Preset low, then toggle, clear and set on compare
    bus(1, 8'h56, 8'h10);
    chk("preset", pinOut[0], 0);
    chk("owns", owns[0], 0);
    chk("oe", pinOe_n[0], 1);
    // Write without the low byte lane is ignored
    byteenable <= 4'hE;
    bus(1, 8'h56, 8'h14);
    byteenable <= 4'hF;
    bus(0, 8'h56, 8'h00); chk("beOff", rd, 16'h0010);
    lfsrR = lfsr(lfsrR);
    v = lfsrR[15:0];
    cnt.value <= v ^ 16'h8000;
    bus(1, 8'h57, v[15:8]);
    bus(1, 8'h58, v[7:0]);
    exO = 0;
    for (int e = 1; e < 4; e++) begin
      bus(1, 8'h56, 8'(8'h10 | (e << 2)));
      tick(v, 1'b0);
      exO = (e == 1) ? 1 - exO : e - 2;
      chk("cmpOut", pinOut[0], exO);
      chk("oeOn", pinOe_n[0], 0);
      bus(0, 8'h56, 8'h00); chk("cmpFlag", rd[7], 1);
    end
    // Event between arming read and clearing write voids the clear
    tick(v, 1'b0);
    bus(1, 8'h56, 8'h1C);
    bus(0, 8'h56, 8'h00); chk("clrIgnored", rd[7], 1);
    // High write suppresses compares until low write
    bus(1, 8'h56, 8'h18);
    bus(1, 8'h57, v[15:8]);
    tick(v, 1'b0); chk("cmpLock", pinOut[0], exO);
    bus(1, 8'h58, v[7:0]);
    tick(v, 1'b0); exO = 0; chk("cmpFree", pinOut[0], exO);
    // Overflow toggles and wins over a coincident set
    bus(1, 8'h56, 8'h1E);
    tick(v ^ 16'h0001, 1'b1); exO = 1 - exO; chk("tovOut", pinOut[0], exO);
    tick(v, 1'b1); exO = 1 - exO; chk("tovWins", pinOut[0], exO);
    // Buffered mode disables channel 1
    bus(1, 8'h59, 8'h04);
    chk("own1", owns[1], 1);
    bus(1, 8'h56, 8'h24);
    bus(1, 8'h59, 8'h0C);
    bus(0, 8'h59, 8'h00); chk("ctrl1Hold", rd, 16'h0004);
    chk("own1Off", owns[1], 0);
    tick(16'h0000, 1'b1);
    tick(v, 1'b0); exO = 1 - exO; chk("bufOut", pinOut[0], exO);
    // New value waits for overflow before use
    w = v ^ 16'h0F0F;
    bus(1, 8'h5A, w[15:8]);
    bus(1, 8'h5B, w[7:0]);
    tick(w, 1'b0); chk("bufWait", pinOut[0], exO);
    tick(16'h0000, 1'b1);
    tick(w, 1'b0); exO = 1 - exO; chk("bufLoad", pinOut[0], exO);
    // Full duty takes hold from the next period
    bus(1, 8'h56, 8'h29);
    tick(w, 1'b0); exO = 0; chk("maxPre", pinOut[0], exO);
    tick(16'h0000, 1'b1); exO = 1;
    tick(w, 1'b0); chk("maxHeld", pinOut[0], exO);
    end_of_test;
  end
endmodule
